// ===== design/obl_pkg.sv
/*
 Package for the option byte configuration loader: option byte addresses,
 field positions, erased values and the loader state type.
 Assumes a byte-wide flash read port whose data is valid one cycle or more
 after the address is presented, flagged by a valid strobe.
*/
// Contract
// - Configuration lives in flash bytes 0000H and 0001H
// - Byte 0 bits [5:4] select oscillator mode
// - Erased oscillator field reads 11, high-power crystal
// - Brown-out bit 0: off in stop if asked
// - Brown-out bit 1: detector always on, stop included
// - Read-protect 0 blocks code, limits debugger commands
// - Read-protect 1 allows code access, all debugger commands
// - Write-protect 0 blocks user program/erase, debugger mass-erase ok
// - Write-protect 1 permits program and erase everywhere
// - Crystal-off bit only gates crystal, not clock choice
// - Crystal-off 0: crystal runs, longer reset; 1: shorter
// - Enabled watchdog cannot be disabled by software
// - Reset never alters stored option byte contents
// - Every reset reloads option bytes into holding registers
// - Hold processor in reset until options loaded
// - New option byte values act only after reset
// - Holding registers not reachable by software
package obl_pkg;
   // ----------------------------------------
   // Addresses and widths
   // ----------------------------------------
   localparam int ADDR_W = 16;
   localparam logic [15:0] OPT0_ADDR = 16'h0000; // First option byte
   localparam logic [15:0] OPT1_ADDR = 16'h0001; // Second option byte
   // ----------------------------------------
   // Field positions, byte 0
   // ----------------------------------------
   localparam int B0_WDOG_ON = 6; // Watchdog always-on option
   localparam int B0_OSC_HI = 5;
   localparam int B0_OSC_LO = 4;
   localparam int B0_BO_AO = 3;
   localparam int B0_RDP = 2;
   localparam int B0_WRP = 0;
   // ----------------------------------------
   // Field positions, byte 1
   // ----------------------------------------
   localparam int B1_XTAL_OFF = 4;
   // ----------------------------------------
   // Values held before load (erased flash)
   // ----------------------------------------
   localparam logic [7:0] OPT0_RESET = 8'hFF;
   localparam logic [7:0] OPT1_RESET = 8'hFF;
   // ----------------------------------------
   // Oscillator mode codes
   // ----------------------------------------
   localparam logic [1:0] OSC_RC = 2'h0;
   localparam logic [1:0] OSC_LOW = 2'h1;
   localparam logic [1:0] OSC_MED = 2'h2;
   localparam logic [1:0] OSC_HIGH = 2'h3;
   // Loader states
   typedef enum logic [2:0] {ST_REQ0, ST_WAIT0, ST_REQ1, ST_WAIT1, ST_DONE} obl_state_t;
endpackage

// ===== design/obl_loader.sv
/*
 Option byte configuration loader: on each reset reads the two option bytes
 from flash, latches them into hidden holding registers and decodes them
 into control levels for oscillator, brown-out, protection, crystal and
 watchdog. Assumes i_rstn is asserted by system reset, power-on reset and
 stop-mode recovery alike, and that flash answers with i_fl_valid.
*/
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module obl_loader
(
   input wire logic i_clk, // 200 MHz system clock
   input wire logic i_rstn, // Any reset, active low
   output logic o_fl_rd, // Flash read request
   output logic [obl_pkg::ADDR_W-1:0] o_fl_addr, // Flash read address
   input wire logic [7:0] i_fl_data, // Flash read data
   input wire logic i_fl_valid, // Flash data valid
   input wire logic i_stop_mode, // Core in stop mode
   input wire logic i_pwr_bo_off, // Power control asks brown-out off
   input wire logic i_dbg_mode, // Access comes from debugger
   input wire logic i_prog_req, // Program or page erase request
   input wire logic i_mass_req, // Mass erase request
   input wire logic i_wdt_sw_en, // Software enables watchdog
   output logic o_load_done, // Options loaded
   output logic o_cpu_rst_n, // CPU reset release, active low
   output logic [1:0] o_oscillator_mode_select, // Oscillator mode
   output logic o_brownout_en, // Brown-out detector enable
   output logic o_code_read_ok, // User code readable
   output logic o_dbg_full, // All debugger commands allowed
   output logic o_prog_grant, // Program/page erase allowed
   output logic o_mass_grant, // Mass erase allowed
   output logic o_xtal_en, // Crystal oscillator enable
   output logic o_long_reset, // Extended reset timing
   output logic o_wdt_en // Watchdog running
);
   import obl_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   // Holding registers are internal only; no bus reaches them
   typedef struct packed
   {
      obl_state_t st; // Loader state
      logic [7:0] opt0; // Hidden copy of byte 0000H
      logic [7:0] opt1; // Hidden copy of byte 0001H
      logic wdt; // Watchdog enabled latch
   } obl_s_t;

   obl_s_t r;
   obl_s_t next_r; // Next state

   // ----------------------------------------
   // Load sequence
   // ----------------------------------------
   // Holding copy is only ever written from flash, never back to it
   always_comb
   begin
      next_r = r;
      case (r.st)
         ST_REQ0: next_r.st = ST_WAIT0;
         ST_WAIT0:
         begin
            // Capture only on valid data
            if (i_fl_valid)
            begin
               next_r.opt0 = i_fl_data;
               next_r.st = ST_REQ1;
            end
         end
         ST_REQ1: next_r.st = ST_WAIT1;
         ST_WAIT1:
         begin
            if (i_fl_valid)
            begin
               next_r.opt1 = i_fl_data;
               next_r.st = ST_DONE;
               // Always-on option starts the watchdog as the load ends
               next_r.wdt = r.wdt | r.opt0[B0_WDOG_ON];
            end
         end
         default:
         begin
            // Running: watchdog only ever turns on, reset turns it off
            if (i_wdt_sw_en)
            begin
               next_r.wdt = 1'h1;
            end
         end
      endcase
   end

   // Reset returns to fresh load; copy reloads so later flash edits apply here
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         r <= '{st: ST_REQ0, opt0: OPT0_RESET, opt1: OPT1_RESET, wdt: 1'h0};
      end
      else
      begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // Flash port and reset release
   // ----------------------------------------
   always_comb
   begin
      // Read-only port: the loader never writes the option bytes back
      o_fl_rd = (r.st == ST_REQ0) || (r.st == ST_REQ1);
      o_fl_addr = (r.st == ST_REQ1 || r.st == ST_WAIT1) ? OPT1_ADDR : OPT0_ADDR;
   end

   assign o_load_done = (r.st == ST_DONE);
   assign o_cpu_rst_n = (r.st == ST_DONE);

   // ----------------------------------------
   // Decoded controls
   // ----------------------------------------
   // Until each byte is captured its option fields show erased values; code read, grants and watchdog stay off until loaded
   always_comb
   begin
      o_oscillator_mode_select = r.opt0[B0_OSC_HI:B0_OSC_LO];
      // Always-on bit overrides the stop request
      o_brownout_en = r.opt0[B0_BO_AO] | ~(i_stop_mode & i_pwr_bo_off);
      o_code_read_ok = r.opt0[B0_RDP] & o_load_done;
      o_dbg_full = r.opt0[B0_RDP];
      o_prog_grant = i_prog_req & o_load_done & r.opt0[B0_WRP];
      o_mass_grant = i_mass_req & o_load_done & (r.opt0[B0_WRP] | i_dbg_mode);
      // Enables crystal only; clock source choice stays with software
      o_xtal_en = ~r.opt1[B1_XTAL_OFF];
      o_long_reset = ~r.opt1[B1_XTAL_OFF];
      o_wdt_en = r.wdt;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_rd0;
      o_fl_rd && o_fl_addr == OPT0_ADDR;
   endsequence
   sequence s_rd1;
      o_fl_rd && o_fl_addr == OPT1_ADDR;
   endsequence

   property p_order;
      @(posedge i_clk) disable iff (!i_rstn) s_rd1 |-> !o_load_done;
   endproperty
   a_order: assert property (p_order) else $error("second read after done");

   property p_rst_hold;
      @(posedge i_clk) disable iff (!i_rstn) !o_load_done |-> !o_cpu_rst_n;
   endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("cpu released early");

   property p_first;
      @(posedge i_clk) disable iff (!i_rstn) $rose(o_load_done) |-> $past(i_fl_valid);
   endproperty
   a_first: assert property (p_first) else $error("done without data");

   property p_cap;
      @(posedge i_clk) disable iff (!i_rstn) (r.st == ST_WAIT0 && i_fl_valid) |=> r.opt0 == $past(i_fl_data);
   endproperty
   a_cap: assert property (p_cap) else $error("byte 0 not captured");

   property p_bo;
      @(posedge i_clk) disable iff (!i_rstn) r.opt0[B0_BO_AO] |-> o_brownout_en;
   endproperty
   a_bo: assert property (p_bo) else $error("brown-out off while always on");

   property p_wrp;
      @(posedge i_clk) disable iff (!i_rstn) !r.opt0[B0_WRP] |-> !o_prog_grant;
   endproperty
   a_wrp: assert property (p_wrp) else $error("program granted while protected");

   property p_mass_dbg;
      @(posedge i_clk) disable iff (!i_rstn) (o_load_done && i_mass_req && i_dbg_mode) |-> o_mass_grant;
   endproperty
   a_mass_dbg: assert property (p_mass_dbg) else $error("debugger mass erase refused");

   property p_wdt;
      @(posedge i_clk) disable iff (!i_rstn) o_wdt_en |=> o_wdt_en;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog turned off");

   property p_seq;
      @(posedge i_clk) disable iff (!i_rstn) s_rd0 |=> !o_fl_rd;
   endproperty
   a_seq: assert property (p_seq) else $error("read strobe longer than one cycle");

   // ----------------------------------------
   // Assertions: load order and capture
   // ----------------------------------------
   // Byte arrival in each wait state; flash may take any number of cycles
   sequence s_byte0;
      r.st == ST_WAIT0 && i_fl_valid;
   endsequence
   sequence s_byte1;
      r.st == ST_WAIT1 && i_fl_valid;
   endsequence

   property p_next_rd;
      @(posedge i_clk) disable iff (!i_rstn) s_byte0 |=> s_rd1;
   endproperty
   a_next_rd: assert property (p_next_rd) else $error("second read not issued after byte 0");

   property p_cap1;
      @(posedge i_clk) disable iff (!i_rstn) s_byte1 |=> r.opt1 == $past(i_fl_data);
   endproperty
   a_cap1: assert property (p_cap1) else $error("byte 1 not captured");

   property p_byte1_done;
      @(posedge i_clk) disable iff (!i_rstn) s_byte1 |=> o_load_done;
   endproperty
   a_byte1_done: assert property (p_byte1_done) else $error("done late after byte 1");

   property p_addr0;
      @(posedge i_clk) disable iff (!i_rstn) (r.st == ST_WAIT0) |-> o_fl_addr == OPT0_ADDR;
   endproperty
   a_addr0: assert property (p_addr0) else $error("address moved while waiting for byte 0");

   property p_addr1;
      @(posedge i_clk) disable iff (!i_rstn) (r.st == ST_WAIT1) |-> o_fl_addr == OPT1_ADDR;
   endproperty
   a_addr1: assert property (p_addr1) else $error("address moved while waiting for byte 1");

   property p_rd1_pulse;
      @(posedge i_clk) disable iff (!i_rstn) s_rd1 |=> !o_fl_rd;
   endproperty
   a_rd1_pulse: assert property (p_rd1_pulse) else $error("second read strobe too long");

   property p_no_rd_done;
      @(posedge i_clk) disable iff (!i_rstn) o_load_done |-> !o_fl_rd;
   endproperty
   a_no_rd_done: assert property (p_no_rd_done) else $error("read after load finished");

   // ----------------------------------------
   // Assertions: holding copy and reset release
   // ----------------------------------------
   // Later flash edits must wait for the next reset
   property p_hold_stable;
      @(posedge i_clk) disable iff (!i_rstn) o_load_done |=> $stable(r.opt0) && $stable(r.opt1);
   endproperty
   a_hold_stable: assert property (p_hold_stable) else $error("holding copy changed without reset");

   property p_done_hold;
      @(posedge i_clk) disable iff (!i_rstn) o_load_done |=> o_load_done && o_cpu_rst_n;
   endproperty
   a_done_hold: assert property (p_done_hold) else $error("processor dropped back into reset");

   property p_prog_before;
      @(posedge i_clk) disable iff (!i_rstn) !o_load_done |-> !o_prog_grant && !o_mass_grant;
   endproperty
   a_prog_before: assert property (p_prog_before) else $error("flash change granted before load");

   // ----------------------------------------
   // Assertions: protection
   // ----------------------------------------
   property p_rdp_lock;
      @(posedge i_clk) disable iff (!i_rstn) (o_load_done && !r.opt0[B0_RDP]) |-> !o_code_read_ok && !o_dbg_full;
   endproperty
   a_rdp_lock: assert property (p_rdp_lock) else $error("code open while read protected");

   property p_rdp_open;
      @(posedge i_clk) disable iff (!i_rstn) (o_load_done && r.opt0[B0_RDP]) |-> o_code_read_ok && o_dbg_full;
   endproperty
   a_rdp_open: assert property (p_rdp_open) else $error("code closed while unprotected");

   property p_wrp_open;
      @(posedge i_clk) disable iff (!i_rstn) (o_load_done && r.opt0[B0_WRP] && i_prog_req) |-> o_prog_grant;
   endproperty
   a_wrp_open: assert property (p_wrp_open) else $error("program refused while unprotected");

   property p_mass_user;
      @(posedge i_clk) disable iff (!i_rstn) (!r.opt0[B0_WRP] && !i_dbg_mode) |-> !o_mass_grant;
   endproperty
   a_mass_user: assert property (p_mass_user) else $error("user mass erase granted while protected");

   // ----------------------------------------
   // Assertions: brown-out and crystal
   // ----------------------------------------
   // Without both stop and the power request the detector stays on
   property p_bo_stop;
      @(posedge i_clk) disable iff (!i_rstn) !(i_stop_mode && i_pwr_bo_off) |-> o_brownout_en;
   endproperty
   a_bo_stop: assert property (p_bo_stop) else $error("brown-out off without power request");

   property p_xtal_on;
      @(posedge i_clk) disable iff (!i_rstn) (o_load_done && !r.opt1[B1_XTAL_OFF]) |-> o_xtal_en && o_long_reset;
   endproperty
   a_xtal_on: assert property (p_xtal_on) else $error("crystal off although enabled");

   property p_xtal_off;
      @(posedge i_clk) disable iff (!i_rstn) (o_load_done && r.opt1[B1_XTAL_OFF]) |-> !o_xtal_en && !o_long_reset;
   endproperty
   a_xtal_off: assert property (p_xtal_off) else $error("crystal on although disabled");

   // ----------------------------------------
   // Assertions: watchdog
   // ----------------------------------------
   property p_wdt_load;
      @(posedge i_clk) disable iff (!i_rstn) !o_load_done |-> !o_wdt_en;
   endproperty
   a_wdt_load: assert property (p_wdt_load) else $error("watchdog on before load");

   property p_sw_en;
      @(posedge i_clk) disable iff (!i_rstn) (o_load_done && i_wdt_sw_en) |=> o_wdt_en;
   endproperty
   a_sw_en: assert property (p_sw_en) else $error("software enable ignored");

   property p_watchdog_always_on;
      @(posedge i_clk) disable iff (!i_rstn) ($rose(o_load_done) && r.opt0[B0_WDOG_ON]) |-> o_wdt_en;
   endproperty
   a_watchdog_always_on: assert property (p_watchdog_always_on) else $error("always-on option did not start watchdog");
endmodule

// ===== test/obl_flash_model.sv
/*
 Flash array model for the option byte loader bench: answers each read
 after a chosen latency with one valid pulse.
 Assumes one outstanding read at a time, on the loader's clock.
*/
`timescale 1ns/1ps
module obl_flash_model
(
   input wire logic i_clk, // Loader clock
   input wire logic i_rstn, // Drops any read in flight
   input wire logic i_rd, // Read request
   input wire logic [15:0] i_addr, // Read address
   input wire logic [7:0] i_b0, // Stored byte at 0000H
   input wire logic [7:0] i_b1, // Stored byte at 0001H
   input wire logic [3:0] i_lat, // Extra wait cycles
   output logic [7:0] o_data, // Read data
   output logic o_valid // Data valid pulse
);
   logic busy = 1'h0; // Read in flight
   logic [3:0] cnt = 4'h0; // Remaining wait
   logic [15:0] addr_q = 16'h0000; // Latched address
   logic [7:0] data_q = 8'hA5; // Bus value
   logic valid_q = 1'h0; // Valid value
   assign o_data = data_q;
   assign o_valid = valid_q;
   // ----------------------------------------
   // Read sequencing
   // ----------------------------------------
   // Idle data toggles so a late capture never sees a stale byte
   always @(posedge i_clk)
   begin
      valid_q <= 1'h0;
      data_q <= ~data_q;
      if (!i_rstn)
      begin
         busy <= 1'h0;
      end
      else if (busy && cnt == 4'h0)
      begin
         busy <= 1'h0;
         valid_q <= 1'h1;
         data_q <= (addr_q == 16'h0000) ? i_b0 : i_b1;
      end
      else if (busy)
      begin
         cnt <= cnt - 4'h1;
      end
      else if (i_rd)
      begin
         busy <= 1'h1;
         cnt <= i_lat;
         addr_q <= i_addr;
      end
   end
endmodule

// ===== test/test_obl_loader.sv
/*
 Bench for the option byte loader: reload, decode, grants and watchdog.
 Assumes the flash model serves reads by address at a set latency.
*/
`timescale 1ns/1ps
module test_obl_loader;
   import obl_pkg::*;
   logic i_clk = 1'h0;
   logic i_rstn = 1'h0;
   logic stop = 1'h0, bo_off = 1'h0, dbg = 1'h0, prog = 1'h0, mass = 1'h0, wsw = 1'h0;
   logic [7:0] b0 = 8'hFF, b1 = 8'hFF, fl_data;
   logic [3:0] lat = 4'h0;
   logic fl_rd, fl_valid, done, cpu_rst_n, bo_en, rd_ok, dbg_full, prog_g, mass_g, xtal_en, long_rst, wdt_en;
   logic [1:0] osc;
   logic [15:0] fl_addr;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   always #2.5 i_clk = ~i_clk;
   obl_loader u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .o_fl_rd(fl_rd), .o_fl_addr(fl_addr),
      .i_fl_data(fl_data), .i_fl_valid(fl_valid), .i_stop_mode(stop), .i_pwr_bo_off(bo_off),
      .i_dbg_mode(dbg), .i_prog_req(prog), .i_mass_req(mass), .i_wdt_sw_en(wsw), .o_load_done(done),
      .o_cpu_rst_n(cpu_rst_n), .o_oscillator_mode_select(osc), .o_brownout_en(bo_en),
      .o_code_read_ok(rd_ok), .o_dbg_full(dbg_full), .o_prog_grant(prog_g), .o_mass_grant(mass_g),
      .o_xtal_en(xtal_en), .o_long_reset(long_rst), .o_wdt_en(wdt_en));
   obl_flash_model u_flash (.i_clk(i_clk), .i_rstn(i_rstn), .i_rd(fl_rd), .i_addr(fl_addr), .i_b0(b0),
      .i_b1(b1), .i_lat(lat), .o_data(fl_data), .o_valid(fl_valid));
   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic report_and_stop;
      if (error_cnt == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Reset, check the erased defaults, wait for the load and judge the decoded levels
   task automatic load(input logic [7:0] v0, input logic [7:0] v1, input logic [3:0] l);
      int n;
      logic [7:0] want;
      n = 0;
      want = {v0[6], v0[5:4], v0[2], v0[2], ~v1[4], ~v1[4], 1'h1};
      @(posedge i_clk);
      b0 <= v0;
      b1 <= v1;
      lat <= l;
      i_rstn <= 1'h0;
      repeat (10) @(posedge i_clk);
      check({cpu_rst_n, done, wdt_en, prog_g, mass_g, bo_en, osc}, {5'h00, 1'h1, OSC_HIGH});
      i_rstn <= 1'h1;
      while (done !== 1'b1 && n < 50)
      begin
         @(negedge i_clk);
         n++;
      end
      check({7'h00, done}, 8'h01);
      check({wdt_en, osc, rd_ok, dbg_full, xtal_en, long_rst, cpu_rst_n}, want);
   endtask
   // Stop-mode brown-out, grants, watchdog latch, late flash change
   task automatic gates(input logic [7:0] v0);
      @(posedge i_clk);
      {stop, bo_off, prog, mass, dbg, wsw} <= 6'h3D;
      @(negedge i_clk);
      check({5'h00, bo_en, prog_g, mass_g}, {5'h00, v0[3], v0[0], v0[0]});
      @(posedge i_clk);
      {stop, dbg, wsw} <= 3'h2;
      b0 <= ~v0 | 8'h02;
      repeat (3) @(negedge i_clk);
      check({3'h0, bo_en, mass_g, wdt_en, osc}, {3'h0, 3'h7, v0[5:4]});
      // Stop alone, without the power request, keeps the detector on
      @(posedge i_clk);
      {stop, bo_off} <= 2'h2;
      @(negedge i_clk);
      check({7'h00, bo_en}, 8'h01);
   endtask
   // Reset cut into a load in flight must restart it from byte 0
   task automatic cut_load(input logic [7:0] v0, input logic [7:0] v1);
      @(posedge i_clk);
      b0 <= v0;
      b1 <= v1;
      lat <= 4'h2;
      i_rstn <= 1'h0;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'h1;
      // Four edges in, the first byte is still on its way
      repeat (4) @(posedge i_clk);
      i_rstn <= 1'h0;
      @(negedge i_clk);
      check({done, cpu_rst_n, wdt_en, rd_ok, osc, bo_en, prog_g}, {4'h0, OSC_HIGH, 1'h1, 1'h0});
      load(v0, v1, 4'h2);
   endtask
   // Hang guard
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end
   initial
   begin
      load(8'hFF, 8'hFF, 4'h0);
      for (int i = 0; i < 4; i++)
      begin
         load({2'h2, i[1:0], i[0], i[1], 1'h1, i[0]}, {3'h7, i[0], 4'hF}, 4'(i * 3));
         gates({2'h2, i[1:0], i[0], i[1], 1'h1, i[0]});
      end
      cut_load(8'hA6, 8'hEF);
      gates(8'hA6);
      report_and_stop();
   end
endmodule
